// >>> logic/sync_serial_channel_pkg.sv
// Package: register map, field layout and constants of the serial channel
package sync_serial_channel_pkg;
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_TXBUF = 12'h004;
    localparam logic [11:0] ADDR_RXBUF = 12'h008;
    localparam logic [11:0] ADDR_RATE  = 12'h00C;
    localparam logic [11:0] ADDR_PINS  = 12'h010;
    localparam int BIT_WIDTH_LO = 0;
    localparam int BIT_ORDER    = 4;
    localparam int BIT_PHASE    = 5;
    localparam int BIT_POLARITY = 6;
    localparam int BIT_ROLE     = 7;
    localparam int BIT_ENABLE   = 15;
    localparam int BIT_BUSY     = 12;
    localparam int BIT_TXFULL   = 13;
    localparam int BIT_RXFULL   = 14;
    localparam int BIT_OE_DATA  = 0;
    localparam int BIT_IDLE_LVL = 1;
    localparam logic [2:0]  WIDTH_MIN   = 3'h1;
    localparam logic [2:0]  WIDTH_RESET = 3'h7;
    localparam logic [15:0] RATE_RESET  = 16'h0000;
    localparam logic [3:0]  CNT_ONE     = 4'h1;
    localparam logic [31:0] ZERO_WORD   = 32'h00000000;
endpackage

// >>> logic/sync_serial_channel.sv
// Serial channel core: APB registers, rate timer, shift engine
`timescale 1ns/100ps
module sync_serial_channel
    import sync_serial_channel_pkg::*;
(
    input  wire logic        pclk,                   // Module clock
    input  wire logic        presetn,                // Async reset, low
    input  wire logic        psel,                   // APB select
    input  wire logic        penable,                // APB access phase
    input  wire logic        pwrite,                 // APB write
    input  wire logic [11:0] paddr,                  // APB byte address
    input  wire logic [31:0] pwdata,                 // APB write data
    output logic      [31:0] prdata,                 // APB read data
    output logic             pready,                 // APB ready
    output logic             pslverr,                // APB error
    input  wire logic        master_in_slave_out_pin, // Data in, master
    input  wire logic        master_out_slave_in_pin, // Data in, slave
    input  wire logic        slave_clock_in,          // Clock in, slave
    output logic             master_out_data,        // Data out, master
    output logic             master_out_data_oe,     // Enable, master data
    output logic             slave_out_data,         // Data out, slave
    output logic             slave_out_data_oe,      // Enable, slave data
    output logic             master_shift_clock_out, // Clock out
    output logic             master_shift_clock_oe,  // Clock pin enable
    output logic             transmit_request_line,  // Pulse, frame start
    output logic             receive_request_line    // Pulse, rx data ready
);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} state_t;

    logic [2:0]  width_reg;
    logic        order_reg, phase_reg, polarity_reg, role_reg, enable_reg;
    logic        slave_oe_reg, idle_lvl_reg;
    logic [15:0] reload_reg, timer_reg;
    logic [7:0]  txbuf_reg, rxbuf_reg, shift_reg;
    logic        txfull_reg, rxfull_reg, busy_reg, loaded_reg;
    logic [3:0]  count_reg;
    state_t      state_reg;
    logic        sclk_reg, sclk_prev_reg, dout_reg;
    logic        tick, wr, rd, frame_done, take_tx, lead_ev, trail_ev;
    logic        out_ev, in_ev, din, start;
    logic [31:0] rd_next;

    // First bit to send for the chosen order
    function automatic logic first_bit(input logic [7:0] d,
                                       input logic [2:0] w,
                                       input logic       msb);
        first_bit = msb ? d[w] : d[0];
    endfunction

    // One received bit in; LSB order lands it at the top frame bit
    function automatic logic [7:0] shift_in(input logic [7:0] s,
                                            input logic       b,
                                            input logic [2:0] w,
                                            input logic       msb);
        if (msb)
            shift_in = {s[6:0], b};
        else
            // Top frame bit cleared so unused high bits never leak in
            shift_in = ((s >> 1) & ~(8'h01 << w)) | ({7'h00, b} << w);
    endfunction

    assign wr   = psel & penable & pwrite;
    assign rd   = psel & penable & ~pwrite;
    assign tick = (timer_reg == RATE_RESET);
    assign din  = role_reg ? master_in_slave_out_pin
                           : master_out_slave_in_pin;

    // Clock edges: master from its own toggle, slave from the pin
    always_comb begin
        lead_ev  = 1'b0;
        trail_ev = 1'b0;
        if (role_reg) begin
            lead_ev  = tick && state_reg == ST_LEAD;
            trail_ev = tick && state_reg == ST_TRAIL;
        end else begin
            lead_ev  = (slave_clock_in != sclk_prev_reg)
                       && (slave_clock_in != polarity_reg);
            trail_ev = (slave_clock_in != sclk_prev_reg)
                       && (slave_clock_in == polarity_reg);
        end
        out_ev = phase_reg ? lead_ev : trail_ev;
        in_ev  = phase_reg ? trail_ev : lead_ev;
    end

    assign frame_done = enable_reg && trail_ev
                        && count_reg == {1'b0, width_reg};
    assign take_tx = enable_reg && txfull_reg
                     && (!loaded_reg || frame_done);
    assign start = enable_reg && loaded_reg && !busy_reg
                   && (role_reg ? tick : lead_ev);

    // Register file and APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_reg    <= WIDTH_RESET;
            order_reg    <= 1'b0;
            phase_reg    <= 1'b0;
            polarity_reg <= 1'b0;
            role_reg     <= 1'b0;
            enable_reg   <= 1'b0;
            reload_reg   <= RATE_RESET;
            slave_oe_reg <= 1'b0;
            idle_lvl_reg <= 1'b0;
        end else if (wr) begin
            if (paddr == ADDR_CTRL) begin
                enable_reg <= pwdata[BIT_ENABLE];
                if (!enable_reg) begin
                    width_reg    <= (pwdata[2:0] < WIDTH_MIN) ? WIDTH_MIN
                                    : pwdata[2:0];
                    order_reg    <= pwdata[BIT_ORDER];
                    phase_reg    <= pwdata[BIT_PHASE];
                    polarity_reg <= pwdata[BIT_POLARITY];
                    role_reg     <= pwdata[BIT_ROLE];
                end
            end
            // Reload locked while running: timer shares its read address
            if (paddr == ADDR_RATE && !enable_reg)
                reload_reg <= pwdata[15:0];
            if (paddr == ADDR_PINS) begin
                slave_oe_reg <= pwdata[BIT_OE_DATA];
                idle_lvl_reg <= pwdata[BIT_IDLE_LVL];
            end
        end
    end

    always_comb begin
        rd_next = ZERO_WORD;
        unique case (paddr)
            ADDR_CTRL: begin
                rd_next[BIT_ENABLE] = enable_reg;
                if (enable_reg) begin
                    rd_next[BIT_BUSY]   = busy_reg;
                    rd_next[BIT_TXFULL] = txfull_reg;
                    rd_next[BIT_RXFULL] = rxfull_reg;
                end else begin
                    rd_next[2:0]          = width_reg;
                    rd_next[BIT_ORDER]    = order_reg;
                    rd_next[BIT_PHASE]    = phase_reg;
                    rd_next[BIT_POLARITY] = polarity_reg;
                    rd_next[BIT_ROLE]     = role_reg;
                end
            end
            ADDR_TXBUF: rd_next[7:0]  = txbuf_reg;
            ADDR_RXBUF: rd_next[7:0]  = rxbuf_reg;
            ADDR_RATE:  rd_next[15:0] = enable_reg ? timer_reg : reload_reg;
            ADDR_PINS: begin
                rd_next[BIT_OE_DATA]  = slave_oe_reg;
                rd_next[BIT_IDLE_LVL] = idle_lvl_reg;
            end
            default:    rd_next = ZERO_WORD;
        endcase
    end

    // Zero-wait slave: answer in the access cycle itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= (psel && !penable && !pwrite) ? rd_next : prdata;
            pready  <= psel && !penable;
            pslverr <= psel && !penable
                       && paddr != ADDR_CTRL && paddr != ADDR_TXBUF
                       && paddr != ADDR_RXBUF && paddr != ADDR_RATE
                       && paddr != ADDR_PINS;
        end
    end

    // Rate timer counts down, reloads at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timer_reg <= RATE_RESET;
        else if (!enable_reg || tick)
            timer_reg <= reload_reg;
        else
            timer_reg <= timer_reg - 16'h0001;
    end

    // Buffers; a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_reg  <= 8'h00;
            txfull_reg <= 1'b0;
            rxbuf_reg  <= 8'h00;
            rxfull_reg <= 1'b0;
        end else begin
            if (wr && paddr == ADDR_TXBUF) begin
                txbuf_reg  <= pwdata[7:0];
                txfull_reg <= 1'b1;
            end else if (take_tx)
                txfull_reg <= 1'b0;
            if (frame_done) begin
                // Trailing-edge sampling takes its last bit on this edge
                rxbuf_reg  <= in_ev ? shift_in(shift_reg, din, width_reg,
                                               order_reg)
                                    : shift_reg;
                rxfull_reg <= 1'b1;
            end else if (rd && paddr == ADDR_RXBUF)
                rxfull_reg <= 1'b0;
        end
    end

    // Shift engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg  <= 8'h00;
            loaded_reg <= 1'b0;
            busy_reg   <= 1'b0;
            count_reg  <= 4'h0;
            state_reg  <= ST_IDLE;
            dout_reg   <= 1'b0;
            transmit_request_line <= 1'b0;
            receive_request_line  <= 1'b0;
        end else begin
            transmit_request_line <= start;
            receive_request_line  <= frame_done;
            if (!enable_reg) begin
                loaded_reg <= 1'b0;
                busy_reg   <= 1'b0;
                state_reg  <= ST_IDLE;
                count_reg  <= 4'h0;
                dout_reg   <= idle_lvl_reg;
            end else begin
                if (take_tx) begin
                    shift_reg  <= txbuf_reg;
                    loaded_reg <= 1'b1;
                    if (!role_reg)
                        dout_reg <= first_bit(txbuf_reg, width_reg,
                                              order_reg);
                end else if (frame_done)
                    loaded_reg <= 1'b0;
                if (start) begin
                    busy_reg  <= 1'b1;
                    state_reg <= ST_LEAD;
                    count_reg <= 4'h0;
                    if (role_reg)
                        dout_reg <= first_bit(shift_reg, width_reg,
                                              order_reg);
                end
                // Slave start is its first clock edge, so shift it too
                if (busy_reg || (start && !role_reg)) begin
                    if (in_ev && !take_tx) begin
                        shift_reg <= shift_in(shift_reg, din, width_reg,
                                              order_reg);
                        if (trail_ev)
                            count_reg <= count_reg + CNT_ONE;
                    end
                    // Leading-phase first bit is already out; keep last bit
                    if (out_ev && (phase_reg ? count_reg != 4'h0
                                             : !frame_done))
                        dout_reg <= first_bit(shift_reg, width_reg,
                                              order_reg);
                    if (!in_ev && trail_ev)
                        count_reg <= count_reg + CNT_ONE;
                    if (role_reg && tick)
                        state_reg <= (state_reg == ST_LEAD) ? ST_TRAIL
                                                            : ST_LEAD;
                    if (frame_done) begin
                        count_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end
                end
            end
        end
    end

    // Master clock toggles at each rate tick while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_reg      <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= slave_clock_in;
            if (!busy_reg || !role_reg)
                sclk_reg <= polarity_reg;
            else if (tick)
                sclk_reg <= ~sclk_reg;
        end
    end

    // Pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_shift_clock_out <= 1'b0;
            master_shift_clock_oe  <= 1'b0;
            master_out_data        <= 1'b0;
            master_out_data_oe     <= 1'b0;
            slave_out_data         <= 1'b0;
            slave_out_data_oe      <= 1'b0;
        end else begin
            master_shift_clock_out <= sclk_reg;
            master_shift_clock_oe  <= enable_reg && role_reg;
            master_out_data        <= dout_reg;
            master_out_data_oe     <= enable_reg && role_reg;
            slave_out_data         <= dout_reg;
            slave_out_data_oe      <= enable_reg && !role_reg
                                      && slave_oe_reg;
        end
    end

    // Checks on the shift engine and pin drivers
    property p_busy_clear;
        @(posedge pclk) disable iff (!presetn)
        frame_done && !take_tx |=> !busy_reg;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy not cleared after frame");

    property p_tx_pulse;
        @(posedge pclk) disable iff (!presetn)
        start |=> transmit_request_line && busy_reg;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("transfer start without busy or request");

    property p_rx_pulse;
        @(posedge pclk) disable iff (!presetn)
        frame_done |=> receive_request_line && rxfull_reg;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("frame end without receive request");

    property p_clk_idle;
        @(posedge pclk) disable iff (!presetn)
        role_reg && !busy_reg
            |-> ##2 master_shift_clock_out == $past(polarity_reg, 2);
    endproperty
    a_clk_idle: assert property (p_clk_idle)
        else $error("idle master clock not at polarity level");

    property p_pin_oe;
        @(posedge pclk) disable iff (!presetn)
        !role_reg |=> !master_shift_clock_oe && !master_out_data_oe;
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("slave drives master clock or data pin");

    property p_slave_wait;
        @(posedge pclk) disable iff (!presetn)
        !role_reg && !busy_reg && !lead_ev |=> !busy_reg;
    endproperty
    a_slave_wait: assert property (p_slave_wait)
        else $error("slave busy set before first clock edge");

    property p_hold_last;
        @(posedge pclk) disable iff (!presetn)
        frame_done && !take_tx |=> $stable(dout_reg);
    endproperty
    a_hold_last: assert property (p_hold_last)
        else $error("data output moved at frame end");

    // Main scenarios to be reached
    c_master_frame: cover property (@(posedge pclk) disable iff (!presetn)
        frame_done && role_reg);
    c_slave_frame: cover property (@(posedge pclk) disable iff (!presetn)
        frame_done && !role_reg);
    c_late_lsb: cover property (@(posedge pclk) disable iff (!presetn)
        frame_done && !order_reg && phase_reg);
    c_status_read: cover property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ADDR_CTRL && enable_reg);
endmodule

// >>> testbench/spi_peer_model.sv
// Far-side serial device: clocked by the master, MSB first
`timescale 1ns/100ps
module spi_peer_model (
    input  wire logic       sclk,    // Clock in only
    input  wire logic       din,     // Data from master
    input  wire logic       cpol,    // Idle clock level
    input  wire logic       cpha,    // 1: shift out on leading edge
    input  wire logic       sel,     // Selected; reloads on rise
    input  wire logic [7:0] tx_word, // Reply, first bit at bit 7
    output logic            dout,    // Data to master
    output logic      [7:0] rx_word  // Bits seen, last at bit 0
);
    logic [7:0] sr;
    int         k;
    initial dout = 1'b1;
    // Deselected line flips so a stale bit never reads as valid
    always @(sel) begin
        if (sel) begin
            sr = tx_word;
            rx_word = 8'h00;
            k = 0;
            if (!cpha) begin
                dout = sr[7];
                k = 1;
            end
        end else begin
            dout = ~dout;
        end
    end
    // Leading edge leaves idle level; one edge shifts, other samples
    always @(sclk) begin
        if (sel && ((sclk != cpol) == cpha)) begin
            if (k < 8) dout = sr[7-k];
            k++;
        end else if (sel) begin
            rx_word = {rx_word[6:0], din};
        end
    end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the serial channel core
`timescale 1ns/100ps
module tb
    import sync_serial_channel_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        miso, mosi, sclk_in, m_do, m_oe, s_do, s_oe;
    logic        sclk, sclk_oe, tx_req, rx_req, tx_seen, rx_seen;
    logic        p_pol, p_pha, p_sel, sclk_last;
    logic [7:0]  p_tx, p_rx;
    int          n_errors, checks_done, cyc, hcnt, half;

    sync_serial_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_in_slave_out_pin(miso), .master_out_slave_in_pin(mosi),
        .slave_clock_in(sclk_in), .master_out_data(m_do),
        .master_out_data_oe(m_oe), .slave_out_data(s_do),
        .slave_out_data_oe(s_oe), .master_shift_clock_out(sclk),
        .master_shift_clock_oe(sclk_oe), .transmit_request_line(tx_req),
        .receive_request_line(rx_req));
    spi_peer_model peer (.sclk(sclk), .din(m_do), .cpol(p_pol),
        .cpha(p_pha), .sel(p_sel), .tx_word(p_tx), .dout(miso),
        .rx_word(p_rx));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Pulses are latched so a short frame is never missed
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tx_req === 1'b1) tx_seen <= 1'b1;
        if (rx_req === 1'b1) rx_seen <= 1'b1;
        if (sclk !== sclk_last) begin
            half <= hcnt;
            hcnt <= 1;
        end else hcnt <= hcnt + 1;
        sclk_last <= sclk;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_seen(input bit rx);
        for (int k = 0; k < 400 && (rx ? rx_seen : tx_seen) !== 1'b1; k++)
            @(posedge pclk);
    endtask

    function automatic logic [7:0] rev(input logic [7:0] v,
                                       input logic [2:0] wm1);
        logic [7:0] o;
        o = 8'h00;
        for (int i = 0; i <= wm1; i++) o[i] = v[wm1-i];
        return o;
    endfunction

    task automatic t_regs();
        logic [31:0] rd;
        logic        e;
        apb(0, ADDR_CTRL, ZERO_WORD, rd, e);
        chk(rd & 32'h000080FF, 32'h00000007);
        apb(0, ADDR_RATE, ZERO_WORD, rd, e);
        chk(rd[15:0], RATE_RESET);
        apb(0, 12'h020, ZERO_WORD, rd, e);
        chk(e, 1'b1);
        $display("registers done");
    endtask

    task automatic t_frame(input logic [2:0] wm1, input logic msb, pha,
                           pol, input logic [7:0] d, r);
        logic [31:0] rd, c;
        logic        e;
        logic [7:0]  m;
        m = 8'hFF >> (3'h7 - wm1);
        c = {24'h0, 1'b1, pol, pha, msb, 1'b0, wm1};
        apb(1, ADDR_CTRL, ZERO_WORD, rd, e);
        p_sel <= 1'b0;
        p_pol <= pol;
        p_pha <= pha;
        p_tx <= r << (3'h7 - wm1);
        apb(1, ADDR_RATE, 32'h00000003, rd, e);
        apb(1, ADDR_CTRL, c, rd, e);
        apb(0, ADDR_CTRL, ZERO_WORD, rd, e);
        chk(rd & 32'h000080FF, c);
        apb(1, ADDR_CTRL, c | 32'h00008000, rd, e);
        p_sel <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({sclk, sclk_oe, m_oe}, {pol, 2'b11});
        tx_seen <= 1'b0;
        rx_seen <= 1'b0;
        apb(1, ADDR_TXBUF, {24'hFFFFFF, d | ~m}, rd, e);
        wait_seen(0);
        chk(tx_seen, 1'b1);
        apb(0, ADDR_CTRL, ZERO_WORD, rd, e);
        chk(rd[BIT_BUSY], 1'b1);
        wait_seen(1);
        chk(rx_seen, 1'b1);
        apb(0, ADDR_CTRL, ZERO_WORD, rd, e);
        chk(rd[BIT_BUSY], 1'b0);
        apb(0, ADDR_RXBUF, ZERO_WORD, rd, e);
        chk(rd[7:0] & m, msb ? r & m : rev(r, wm1));
        chk(p_rx & m, msb ? d & m : rev(d, wm1));
        chk(m_do, msb ? d[0] : d[wm1]);
        chk(half, 4);
        $display("frame width %0d mode %0d%0d%0d done", wm1 + 1, msb,
                 pha, pol);
    endtask

    task automatic t_slave();
        logic [31:0] rd;
        logic        e;
        apb(1, ADDR_CTRL, ZERO_WORD, rd, e);
        apb(1, ADDR_PINS, 32'h00000001, rd, e);
        apb(1, ADDR_CTRL, 32'h00000017, rd, e);
        apb(1, ADDR_CTRL, 32'h00008017, rd, e);
        rx_seen <= 1'b0;
        apb(1, ADDR_TXBUF, 32'h000000A5, rd, e);
        repeat (4) @(posedge pclk);
        chk({s_do, s_oe, sclk_oe, m_oe}, 4'b1100);
        apb(0, ADDR_CTRL, ZERO_WORD, rd, e);
        chk(rd[BIT_BUSY], 1'b0);
        for (int k = 7; k >= 0; k--) begin
            mosi <= k[0] ^ k[1];
            repeat (4) @(posedge pclk);
            sclk_in <= 1'b1;
            repeat (4) @(posedge pclk);
            sclk_in <= 1'b0;
        end
        wait_seen(1);
        apb(0, ADDR_RXBUF, ZERO_WORD, rd, e);
        chk(rd[7:0], 8'h66);
        apb(1, ADDR_CTRL, ZERO_WORD, rd, e);
        $display("slave frame done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, mosi, sclk_in} = 6'h00;
        {paddr, pwdata, p_sel, p_pol, p_pha, p_tx} = '0;
        {tx_seen, rx_seen, sclk_last} = 3'h0;
        {n_errors, checks_done, cyc, hcnt, half} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int i = 0; i < 8; i++)
            t_frame((i % 3 == 0) ? 3'h1 : (i % 3 == 1) ? 3'h7 : 3'h4,
                    i[2], i[1], i[0], 8'(8'hB4 ^ (i * 8'h1D)), 8'(8'h69 + i));
        t_slave();
        close_out();
    end
endmodule
